// *** hw/tacs_pkg.sv ***
// Constants, enumerations and register map of the acquisition stream correlator.
// Assumes a single 40 MHz clock and a plain strobe register port.
// Functional notes
// - Channel list holds up to eight entries, each one stream source.
// - Sources: four analog inputs, period counter, phase counter, optional gate counter.
// - Period counter delivers a 31-bit value into the stream.
// - Period counter counts 12 MHz ticks between two same-polarity tach edges.
// - Counter entries sample under the same clock and trigger as analog ones.
// - Phase counter counts 40 MHz clk cycles between tach edge and sample completion.
// - Gate counter counts 40 MHz clk cycles between sample or gate events.
// - First analog conversion arrives only after 38 sample clock pulses.
// - Counter readings are delayed to line up with their analog samples.
// - Output converter needs 29 output clocks before first conversion completes.
// - Output starts on software, external or analog threshold trigger.
// - Output update clock programmable from 10 kHz to 52.734 kHz.
// - Current output value readable in the input stream during acquisition.
// - Sensor break flagged on DC coupling, excitation on, positive full scale.
// - Each analog channel has excitation enable and AC/DC coupling settings.
// - Each analog input selects gain 1 or 10.
// - Output channel takes 24-bit codes.
// - External trigger starts operation on a low-to-high transition.
// - Converter master clock is 512 times the sample frequency.
package tacs_pkg;

  localparam int CLK_HZ        = 40000000;
  localparam int NUM_AIN       = 4;
  localparam int LIST_MAX      = 8;
  localparam int ADC_DELAY     = 38;
  localparam int DAC_DELAY     = 29;
  localparam int MCLK_RATIO    = 512;
  localparam int TB_SLOW_HZ    = 12000000;
  localparam int TB_FAST_HZ    = 48000000;
  localparam int OUT_MIN_HZ    = 10000;
  localparam int OUT_MAX_MHZ   = 52734000;
  localparam int DIV_MIN       = int'((64'(CLK_HZ) * 64'(1000) + 64'(OUT_MAX_MHZ) - 64'(1)) /
                                      64'(OUT_MAX_MHZ));
  localparam int DIV_MAX       = CLK_HZ / OUT_MIN_HZ;
  localparam logic [31:0] SLOW_STEP = 32'(((64'(TB_SLOW_HZ)) << 32) / CLK_HZ);

  // Register byte addresses
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_LIST_LEN = 8'h04;
  localparam logic [7:0] A_LIST0    = 8'h08;
  localparam logic [7:0] A_SDIV     = 8'h28;
  localparam logic [7:0] A_ODIV     = 8'h2c;
  localparam logic [7:0] A_OCODE    = 8'h30;
  localparam logic [7:0] A_CHCFG    = 8'h34;
  localparam logic [7:0] A_THRESH   = 8'h38;
  localparam logic [7:0] A_STATUS   = 8'h3c;
  localparam logic [7:0] A_PERIOD   = 8'h40;
  localparam logic [7:0] A_PHASE    = 8'h44;

  // Control bits
  localparam int C_RUN   = 0;
  localparam int C_SWTRG = 1;
  localparam int C_TSRC  = 2;
  localparam int C_EDGE  = 4;
  localparam int C_PDIR  = 5;
  localparam int C_OEN   = 6;
  localparam int C_GATE  = 7;

  localparam logic [31:0] SDIV_RST = 32'h0000_0320;
  localparam logic [31:0] ODIV_RST = 32'h0000_0320;

  typedef enum logic [1:0] {
    TACS_TRG_SW  = 2'b00,
    TACS_TRG_EXT = 2'b01,
    TACS_TRG_ANA = 2'b10
  } tacs_trg_t;

  typedef enum logic [2:0] {
    TACS_SRC_AIN0 = 3'b000,
    TACS_SRC_AIN1 = 3'b001,
    TACS_SRC_AIN2 = 3'b010,
    TACS_SRC_AIN3 = 3'b011,
    TACS_SRC_PER  = 3'b100,
    TACS_SRC_PHS  = 3'b101,
    TACS_SRC_GATE = 3'b110,
    TACS_SRC_DAC  = 3'b111
  } tacs_src_t;

  typedef enum logic [1:0] {
    TACS_IDLE = 2'b00,
    TACS_ARM  = 2'b01,
    TACS_RUN  = 2'b10
  } tacs_state_t;

endpackage

// *** hw/tacs_top.sv ***
// Acquisition stream sequencer with tachometer, phase and gate counters.
// Assumes converter sample strobes and inputs synchronous to clk.
module tacs_top
  import tacs_pkg::*;
#(
  parameter int HAS_GATE = 1,
  parameter int CW       = 32
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        tach_in,
  input  wire logic        gate_in,
  input  wire logic        external_trigger_input,
  input  wire logic        adc_done,
  input  wire logic [95:0] adc_data,
  output logic             adc_mclk_en,
  output logic             dac_clk_en,
  output logic      [23:0] dac_code,
  output logic      [3:0]  exc_en,
  output logic      [3:0]  dc_couple,
  output logic      [3:0]  gain10,
  output logic      [3:0]  sensor_break,
  output logic             stream_valid,
  output logic      [2:0]  stream_src,
  output logic      [31:0] stream_data
);

  logic [31:0] ctrl_q, len_q, sdiv_q, odiv_q, ocode_q, chcfg_q, thr_q;
  logic [2:0]  list_q [LIST_MAX];
  tacs_state_t st_q;
  logic        tach_q, gate_q, trg_q;
  logic [31:0] slow_acc_q;
  logic [30:0] per_cnt_q, per_q;
  logic [CW-1:0] phs_cnt_q, phs_q, gat_cnt_q, gat_q;
  logic        phs_arm_q;
  logic [5:0]  adc_pulses_q;
  logic [4:0]  dac_pulses_q;
  logic [31:0] mdiv_q, odc_q;
  logic [3:0]  seq_q;
  logic        seq_busy_q;
  logic [30:0] per_dly_q [ADC_DELAY];
  logic [CW-1:0] phs_dly_q [ADC_DELAY];
  logic [CW-1:0] gat_dly_q [ADC_DELAY];
  logic [23:0] dac_rb_q;

  logic tach_edge, gate_edge, slow_tick, start, ana_hit;
  logic [31:0] mdiv_lim;
  logic [32:0] slow_sum;
  logic [95:0] ain_q;
  logic [31:0] odiv_eff;

  assign tach_edge = ctrl_q[C_EDGE] ? (tach_q & ~tach_in) : (~tach_q & tach_in);
  assign gate_edge = ~gate_q & gate_in;
  assign slow_sum  = 33'(slow_acc_q) + 33'(SLOW_STEP);
  assign slow_tick = slow_sum[32];
  assign ana_hit = $signed(adc_data[23:0]) > $signed(thr_q[23:0]);
  // Master clock period is sample period over the oversampling ratio
  assign mdiv_lim = sdiv_q / MCLK_RATIO;
  // Output divider clamped to the legal update range
  assign odiv_eff = (odiv_q < 32'(DIV_MIN)) ? 32'(DIV_MIN) :
                    (odiv_q > 32'(DIV_MAX)) ? 32'(DIV_MAX) : odiv_q;

  always_comb begin
    start = 1'b0;
    case (tacs_trg_t'(ctrl_q[C_TSRC +: 2]))
      TACS_TRG_SW:  start = ctrl_q[C_SWTRG];
      TACS_TRG_EXT: start = ~trg_q & external_trigger_input;
      TACS_TRG_ANA: start = adc_done & ana_hit;
      default:      start = 1'b0;
    endcase
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q  <= 32'h0;
      len_q   <= 32'h0;
      sdiv_q  <= SDIV_RST;
      odiv_q  <= ODIV_RST;
      ocode_q <= 32'h0;
      chcfg_q <= 32'h0;
      thr_q   <= 32'h0;
      for (int i = 0; i < LIST_MAX; i++) begin
        list_q[i] <= 3'h0;
      end
    end else begin
      ctrl_q[C_SWTRG] <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          A_CTRL:     ctrl_q  <= reg_wdata;
          A_LIST_LEN: len_q   <= (reg_wdata > 32'(LIST_MAX)) ? 32'(LIST_MAX) : reg_wdata;
          A_SDIV:     sdiv_q  <= reg_wdata;
          A_ODIV:     odiv_q  <= reg_wdata;
          A_OCODE:    ocode_q <= {8'h0, reg_wdata[23:0]};
          A_CHCFG:    chcfg_q <= {20'h0, reg_wdata[11:0]};
          A_THRESH:   thr_q   <= reg_wdata;
          default: begin
            for (int i = 0; i < LIST_MAX; i++) begin
              if (reg_addr == A_LIST0 + 8'(4 * i)) begin
                list_q[i] <= reg_wdata[2:0];
              end
            end
          end
        endcase
      end
    end
  end

  // Register reads
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        A_CTRL:     reg_rdata <= ctrl_q;
        A_LIST_LEN: reg_rdata <= len_q;
        A_SDIV:     reg_rdata <= sdiv_q;
        A_ODIV:     reg_rdata <= odiv_q;
        A_OCODE:    reg_rdata <= ocode_q;
        A_CHCFG:    reg_rdata <= chcfg_q;
        A_THRESH:   reg_rdata <= thr_q;
        A_STATUS:   reg_rdata <= {24'h0, sensor_break, 2'h0, st_q};
        A_PERIOD:   reg_rdata <= {1'b0, per_q};
        A_PHASE:    reg_rdata <= 32'(phs_q);
        default:    reg_rdata <= 32'h0;
      endcase
    end
  end

  // Input history and trigger state
  always_ff @(posedge clk) begin
    if (rst) begin
      tach_q <= 1'b0;
      gate_q <= 1'b0;
      trg_q  <= 1'b0;
      st_q   <= TACS_IDLE;
    end else begin
      tach_q <= tach_in;
      gate_q <= gate_in;
      trg_q  <= external_trigger_input;
      case (st_q)
        TACS_IDLE: if (ctrl_q[C_RUN]) st_q <= TACS_ARM;
        TACS_ARM:  if (!ctrl_q[C_RUN]) st_q <= TACS_IDLE;
                   else if (start) st_q <= TACS_RUN;
        TACS_RUN:  if (!ctrl_q[C_RUN]) st_q <= TACS_IDLE;
        default:   st_q <= TACS_IDLE;
      endcase
    end
  end

  // 12 MHz fractional tick for the period counter
  always_ff @(posedge clk) begin
    if (rst) begin
      slow_acc_q <= 32'h0;
    end else begin
      slow_acc_q <= slow_acc_q + SLOW_STEP;
    end
  end

  // Period counter, 31 bits, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      per_cnt_q <= 31'h0;
      per_q     <= 31'h0;
    end else if (tach_edge) begin
      per_q     <= per_cnt_q;
      per_cnt_q <= 31'h0;
    end else if (slow_tick && per_cnt_q != '1) begin
      per_cnt_q <= per_cnt_q + 31'h1;
    end
  end

  // Phase counter: edge to sample or sample to edge, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      phs_cnt_q <= '0;
      phs_q     <= '0;
      phs_arm_q <= 1'b0;
    end else begin
      if ((ctrl_q[C_PDIR] ? adc_done : tach_edge) && !phs_arm_q) begin
        phs_arm_q <= 1'b1;
        phs_cnt_q <= '0;
      end else if ((ctrl_q[C_PDIR] ? tach_edge : adc_done) && phs_arm_q) begin
        phs_arm_q <= 1'b0;
        phs_q     <= phs_cnt_q;
      end else if (phs_arm_q && phs_cnt_q != '1) begin
        phs_cnt_q <= phs_cnt_q + CW'(TB_FAST_HZ / CLK_HZ);
      end
    end
  end

  // Gate counter between sample or gate events
  always_ff @(posedge clk) begin
    if (rst) begin
      gat_cnt_q <= '0;
      gat_q     <= '0;
    end else if (HAS_GATE != 0 && (adc_done || (ctrl_q[C_GATE] && gate_edge))) begin
      gat_q     <= gat_cnt_q;
      gat_cnt_q <= '0;
    end else if (gat_cnt_q != '1) begin
      gat_cnt_q <= gat_cnt_q + CW'(TB_FAST_HZ / CLK_HZ);
    end
  end

  // Converter clocks and startup pulse counts
  always_ff @(posedge clk) begin
    if (rst || st_q != TACS_RUN) begin
      mdiv_q       <= 32'h0;
      odc_q        <= 32'h0;
      adc_mclk_en  <= 1'b0;
      dac_clk_en   <= 1'b0;
      adc_pulses_q <= 6'h0;
      dac_pulses_q <= 5'h0;
    end else begin
      adc_mclk_en <= (mdiv_q + 32'h1 >= mdiv_lim);
      mdiv_q      <= (mdiv_q + 32'h1 >= mdiv_lim) ? 32'h0 : mdiv_q + 32'h1;
      dac_clk_en  <= ctrl_q[C_OEN] && (odc_q + 32'h1 >= odiv_eff);
      odc_q       <= (odc_q + 32'h1 >= odiv_eff) ? 32'h0 : odc_q + 32'h1;
      if (adc_done && adc_pulses_q != 6'(ADC_DELAY)) adc_pulses_q <= adc_pulses_q + 6'h1;
      if (dac_clk_en && dac_pulses_q != 5'(DAC_DELAY)) dac_pulses_q <= dac_pulses_q + 5'h1;
    end
  end

  // Output code and readback after the converter latency
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_code <= 24'h0;
      dac_rb_q <= 24'h0;
    end else if (dac_clk_en) begin
      dac_code <= ocode_q[23:0];
      if (dac_pulses_q == 5'(DAC_DELAY)) dac_rb_q <= dac_code;
    end
  end

  // Counter delay lines matching converter group delay
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < ADC_DELAY; i++) begin
        per_dly_q[i] <= 31'h0;
        phs_dly_q[i] <= '0;
        gat_dly_q[i] <= '0;
      end
    end else if (adc_done) begin
      per_dly_q[0] <= per_q;
      phs_dly_q[0] <= phs_q;
      gat_dly_q[0] <= gat_q;
      for (int i = 1; i < ADC_DELAY; i++) begin
        per_dly_q[i] <= per_dly_q[i-1];
        phs_dly_q[i] <= phs_dly_q[i-1];
        gat_dly_q[i] <= gat_dly_q[i-1];
      end
    end
  end

  // Channel settings and break detection
  always_ff @(posedge clk) begin
    if (rst) begin
      exc_en       <= 4'h0;
      dc_couple    <= 4'h0;
      gain10       <= 4'h0;
      sensor_break <= 4'h0;
    end else begin
      exc_en    <= chcfg_q[3:0];
      dc_couple <= chcfg_q[7:4];
      gain10    <= chcfg_q[11:8];
      if (adc_done) begin
        for (int c = 0; c < NUM_AIN; c++) begin
          sensor_break[c] <= dc_couple[c] & exc_en[c] &
                             (adc_data[24*c +: 24] == 24'h7f_ffff);
        end
      end
    end
  end

  // Converter codes held for the burst after a completion
  always_ff @(posedge clk) begin
    if (rst) begin
      ain_q <= 96'h0;
    end else if (adc_done) begin
      ain_q <= adc_data;
    end
  end

  // List sequencer: one word per entry in order per sample
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q        <= 4'h0;
      seq_busy_q   <= 1'b0;
      stream_valid <= 1'b0;
      stream_src   <= 3'h0;
      stream_data  <= 32'h0;
    end else begin
      stream_valid <= 1'b0;
      if (adc_done && st_q == TACS_RUN && adc_pulses_q == 6'(ADC_DELAY) && len_q != 32'h0) begin
        seq_busy_q <= 1'b1;
        seq_q      <= 4'h0;
      end else if (seq_busy_q) begin
        stream_valid <= 1'b1;
        stream_src   <= list_q[seq_q[2:0]];
        case (tacs_src_t'(list_q[seq_q[2:0]]))
          TACS_SRC_PER:  stream_data <= {1'b0, per_dly_q[ADC_DELAY-1]};
          TACS_SRC_PHS:  stream_data <= 32'(phs_dly_q[ADC_DELAY-1]);
          TACS_SRC_GATE: stream_data <= 32'(gat_dly_q[ADC_DELAY-1]);
          TACS_SRC_DAC:  stream_data <= {{8{dac_rb_q[23]}}, dac_rb_q};
          default: begin
            stream_data <= {{8{ain_q[24*list_q[seq_q[2:0]][1:0] + 23]}},
                            ain_q[24*list_q[seq_q[2:0]][1:0] +: 24]};
          end
        endcase
        if (32'(seq_q) + 32'h1 >= len_q) seq_busy_q <= 1'b0;
        seq_q <= seq_q + 4'h1;
      end
    end
  end

endmodule

// *** tb/tacs_adc_model.sv ***
// Converter-side model: sample completion pulses with four channel codes.
// Assumes one clk domain; data reads valid only in the completion cycle.
module tacs_adc_model #(
  parameter int SPACE = 24
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        en,
  input  wire logic [95:0] smp,
  output logic             adc_done,
  output logic      [95:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;

  // One completion serves analog and counter entries alike
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q    <= 8'h00;
      adc_done <= 1'b0;
      adc_data <= 96'h0;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (en) begin
        cnt_q <= (cnt_q == 8'(SPACE - 1)) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == 8'(SPACE - 1)) begin
          adc_done <= 1'b1;
          adc_data <= smp;
        end
      end
    end
  end
endmodule

// *** tb/tacs_top_props.sv ***
// Port checker for the stream correlator.
// Assumes binding onto tacs_top, one clock, synchronous reset.
module tacs_top_props
  import tacs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        adc_done,
  input wire logic [95:0] adc_data,
  input wire logic        dac_clk_en,
  input wire logic [3:0]  exc_en,
  input wire logic [3:0]  dc_couple,
  input wire logic [3:0]  gain10,
  input wire logic [3:0]  sensor_break,
  input wire logic        stream_valid,
  input wire logic [2:0]  stream_src,
  input wire logic [31:0] stream_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  done_n_q;
  logic [3:0]  burst_q;
  logic [11:0] gap_q;

  always_ff @(posedge clk) begin
    if (rst) done_n_q <= 6'h00;
    else if (adc_done && done_n_q != 6'h3f) done_n_q <= done_n_q + 6'h01;
  end
  always_ff @(posedge clk) begin
    if (rst || !stream_valid) burst_q <= 4'h0;
    else if (burst_q != 4'hf) burst_q <= burst_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) gap_q <= 12'hfff;
    else if (dac_clk_en) gap_q <= 12'h000;
    else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_list_len_max: assert property (stream_valid |-> burst_q < 4'h8)
    else $error("stream burst longer than eight words");
  a_ain_sign_ext: assert property (stream_valid && stream_src < 3'h4 |->
    stream_data[31:24] == {8{stream_data[23]}})
    else $error("analog word not sign extended");
  a_per_31bit: assert property (stream_valid && stream_src == TACS_SRC_PER |->
    !stream_data[31])
    else $error("period word wider than 31 bits");
  a_first_conv_gap: assert property (stream_valid |-> done_n_q >= 6'd38)
    else $error("stream word before 38 completions");
  a_burst_after_done: assert property ($rose(stream_valid) |-> $past(adc_done, 2))
    else $error("burst start not two cycles after completion");
  a_break_set: assert property (adc_done && exc_en[0] && dc_couple[0] &&
    adc_data[23:0] == 24'h7fffff |=> sensor_break[0])
    else $error("break not flagged at full scale");
  a_break_clr: assert property (adc_done && !dc_couple[0] |=> !sensor_break[0])
    else $error("break flagged with ac coupling");
  a_chcfg_apply: assert property (reg_wr && reg_addr == A_CHCFG |=> ##1
    {gain10, dc_couple, exc_en} == $past(reg_wdata[11:0], 2))
    else $error("channel settings not applied");
  a_dac_rate: assert property (dac_clk_en |-> gap_q >= 12'd758)
    else $error("output update faster than allowed");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h80 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind tacs_top tacs_top_props u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_done(adc_done), .adc_data(adc_data),
  .dac_clk_en(dac_clk_en), .exc_en(exc_en), .dc_couple(dc_couple), .gain10(gain10),
  .sensor_break(sensor_break), .stream_valid(stream_valid), .stream_src(stream_src),
  .stream_data(stream_data)
);

// *** tb/tacs_top_tb.sv ***
// Self-checking bench for the stream correlator.
// Assumes the converter model and the bound checker beside the design.
module tacs_top_tb
  import tacs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam tacs_src_t LST [8] = '{TACS_SRC_AIN0, TACS_SRC_PER, TACS_SRC_AIN3, TACS_SRC_DAC,
                                    TACS_SRC_PHS, TACS_SRC_AIN1, TACS_SRC_GATE, TACS_SRC_AIN2};
  logic        clk, rst, reg_wr, reg_rd, tach_in, gate_in, external_trigger_input;
  logic        adc_done, adc_mclk_en, dac_clk_en, stream_valid, mdl_en, brk;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, stream_data, rv, rng, ocode, cfg, d;
  logic [95:0] smp, adc_data, last, t;
  logic [23:0] dac_code;
  logic [3:0]  exc_en, dc_couple, gain10, sensor_break;
  logic [2:0]  stream_src;
  int          num_errors, n_checks, tc, pre;

  tacs_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tach_in(tach_in),
    .gate_in(gate_in), .external_trigger_input(external_trigger_input),
    .adc_done(adc_done), .adc_data(adc_data), .adc_mclk_en(adc_mclk_en),
    .dac_clk_en(dac_clk_en), .dac_code(dac_code), .exc_en(exc_en), .dc_couple(dc_couple),
    .gain10(gain10), .sensor_break(sensor_break), .stream_valid(stream_valid),
    .stream_src(stream_src), .stream_data(stream_data));
  tacs_adc_model u_mdl (.clk(clk), .rst(rst), .en(mdl_en), .smp(smp),
    .adc_done(adc_done), .adc_data(adc_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wait_valid();
    for (int k = 0; k < 2000; k++) begin
      @(posedge clk);
      #1;
      if (stream_valid === 1'b1) return;
    end
    num_errors++;
    test_done();
  endtask

  // Tach period 40 clk = 1 us; gate toggles on its own pattern
  always @(posedge clk) begin
    tc      <= (tc == 19) ? 0 : tc + 1;
    tach_in <= (tc == 19) ? ~tach_in : tach_in;
    gate_in <= (tc == 7) ? ~gate_in : gate_in;
    if (stream_valid === 1'b1 && !external_trigger_input) pre++;
  end

  always @(posedge clk) begin
    if (adc_done === 1'b1) begin
      last = adc_data;
      t = {xs(), xs(), xs()};
      if (brk) t[23:0] = 24'h7fffff;
      smp <= t;
    end
  end

  initial begin
    rng = 32'd40; num_errors = 0; n_checks = 0; tc = 0; pre = 0;
    rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    tach_in = 1'b0; gate_in = 1'b0; external_trigger_input = 1'b0;
    mdl_en = 1'b0; brk = 1'b0; smp = 96'h0; last = 96'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cfg = (xs() & 32'h0000_0fff) | 32'h0000_0011;
    wr(A_CHCFG, cfg);
    @(posedge clk);
    #1;
    chk("exc_dc", {24'h0, dc_couple, exc_en}, {24'h0, cfg[7:0]});
    chk("gain10", {28'h0, gain10}, {28'h0, cfg[11:8]});
    ocode = xs() & 32'h00ff_ffff;
    wr(A_OCODE, ocode);
    wr(A_LIST_LEN, 32'h8);
    for (int i = 0; i < 8; i++) wr(A_LIST0 + 8'(4 * i), {29'h0, LST[i]});
    wr(A_ODIV, 32'h0);
    wr(A_CTRL, 32'h0000_0045);
    rd(8'h80, rv);
    chk("unmapped", rv, 32'h0);
    mdl_en <= 1'b1;
    repeat (1200) @(posedge clk);
    chk("pre_trigger", 32'(pre), 32'h0);
    external_trigger_input <= 1'b1;
    // Output path needs its startup pulses before readback is live
    repeat (24000) @(posedge clk);
    #1;
    for (int k = 0; k < 16 && stream_valid === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    for (int b = 0; b < 6; b++) begin
      if (b == 3) brk <= 1'b1;
      wait_valid();
      for (int i = 0; i < 8; i++) begin
        d = stream_data;
        chk("src", {29'h0, stream_src}, {29'h0, LST[i]});
        if (LST[i] < 4) chk("ain", d, 32'(signed'(last[24 * LST[i] +: 24])));
        if (LST[i] == TACS_SRC_PER) chk("period", 32'(d >= 11 && d <= 13), 32'h1);
        if (LST[i] == TACS_SRC_DAC) chk("readback", {8'h0, d[23:0]}, ocode);
        if (LST[i] == TACS_SRC_PHS) chk("phase", 32'(d < 32'h18), 32'h1);
        if (LST[i] == TACS_SRC_GATE) chk("gate", 32'(d == 32'h17 || d == 32'h18), 32'h1);
        @(posedge clk);
        #1;
      end
      chk("burst_end", {31'h0, stream_valid}, 32'h0);
    end
    chk("break_pin", {31'h0, sensor_break[0]}, 32'h1);
    rd(A_STATUS, rv);
    chk("break_reg", {31'h0, rv[4]}, 32'h1);
    chk("dac_code", {8'h0, dac_code}, ocode);
    chk("mclk_en", {31'h0, adc_mclk_en}, 32'h1);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h1);
    rd(A_STATUS, rv);
    chk("armed", {30'h0, rv[1:0]}, 32'h1);
    wr(A_CTRL, 32'h3);
    rd(A_STATUS, rv);
    chk("sw_start", {30'h0, rv[1:0]}, 32'h2);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h9);
    repeat (30) @(posedge clk);
    rd(A_STATUS, rv);
    chk("ana_start", {30'h0, rv[1:0]}, 32'h2);
    test_done();
  end
endmodule
